// *** inc/irq_mask_map.vh ***
`ifndef IRQ_MASK_MAP_VH
`define IRQ_MASK_MAP_VH
`define IRQ_MASK_SET_VIEW_OFS 8'h10
`define IRQ_MASK_CLEAR_VIEW_OFS 8'h14
`define IRQ_EVENT_REG_OFS 8'h0c
`define IRQ_MASK_RESET 32'h00000000
`define IRQ_MASK_IMPL 32'hc000007f
`define BIT_MASTER_IRQ_GATE 31
`define BIT_OWNERSHIP_CHANGE 30
`define BIT_ROOT_HUB_CHANGE 6
`define BIT_FRAME_COUNT_WRAP 5
`define BIT_FATAL_SYSTEM_ERROR 4
`define BIT_RESUME_SEEN 3
`define BIT_FRAME_START 2
`define BIT_DONE_LIST_WRITTEN 1
`define BIT_SCHEDULE_OVERRUN 0
`endif

// *** rtl/irq_mask_store.v ***
`timescale 1ns/1ps
`include "irq_mask_map.vh"
module irq_mask_store (
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_soft_rst,
    input wire i_set_we,
    input wire i_clr_we,
    input wire [31:0] i_wdata,
    input wire [3:0] i_be,
    output wire [31:0] o_mask
);
    reg [31:0] mask_ff;
    reg [31:0] nxt_mask;
    wire [31:0] lane;
    wire [31:0] bits;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            assign lane[g*8 +: 8] = {8{i_be[g]}};
        end
    endgenerate
    // Reserved positions never store, so they always read back zero.
    assign bits = i_wdata & lane & `IRQ_MASK_IMPL;
    always @* begin
        nxt_mask = mask_ff;
        if (i_set_we) begin
            nxt_mask = nxt_mask | bits;
        end
        if (i_clr_we) begin
            nxt_mask = nxt_mask & ~bits;
        end
    end
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_ff <= `IRQ_MASK_RESET;
        end else if (i_soft_rst) begin
            mask_ff <= `IRQ_MASK_RESET;
        end else begin
            mask_ff <= nxt_mask;
        end
    end
    assign o_mask = mask_ff;
endmodule

// *** rtl/irq_gate.v ***
`timescale 1ns/1ps
`include "irq_mask_map.vh"
module irq_gate (
    input wire [31:0] i_mask,
    input wire [31:0] i_events,
    output wire o_req
);
    wire [31:0] impl;
    assign impl = `IRQ_MASK_IMPL;
    // Bits 30..0 of event and mask pair by position; bit 31 gates them all.
    assign o_req = i_mask[`BIT_MASTER_IRQ_GATE] & (|(i_events[30:0] & i_mask[30:0] & impl[30:0]));
endmodule

// *** rtl/usb_host_irq_mask_set_clear.v ***
`timescale 1ns/1ps
`include "irq_mask_map.vh"
// Contract
// - Clear view write 1 clears mask bit.
// - Clear view write 0 leaves bit alone.
// - Clear view reads return current mask.
// - Clear view is 32-bit at 0x14.
// - Clear bits map to event positions.
// - Bit 31 master gate blocks all.
// - Reset leaves interrupts disabled.
// - Bit 30 masks ownership change.
// - Bit 6 masks root hub change.
// - Bit 5 masks frame count wrap.
// - Bit 4 masks fatal system error.
// - Bit 3 masks resume seen.
// - Bit 2 masks frame start.
// - Bit 1 masks done list written.
// - Bit 0 masks schedule overrun.
// - Interrupt needs event, mask and gate.
// - Set view write 1 sets bit.
// - Set view at 0x10, reads mask.
module usb_host_irq_mask_set_clear (
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_soft_rst,
    input wire [7:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [3:0] i_be,
    input wire [31:0] i_wdata,
    input wire [31:0] i_irq_events,
    output reg [31:0] o_rdata,
    output reg o_rvalid,
    output reg o_irq_req
);

    // Both views are decoded the same way, so one comparison serves them.
    function view_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            view_hit = (addr == ofs);
        end
    endfunction

    wire hit_set;
    wire hit_clr;
    wire hit_view;
    wire set_we;
    wire clr_we;
    wire [31:0] mask;
    wire [31:0] read_view;
    wire [31:0] events_seen;
    wire [31:0] write_bits;
    wire req;
    reg [31:0] nxt_rdata;
    reg nxt_rvalid;
    reg nxt_irq_req;

    assign hit_set = view_hit(i_addr, `IRQ_MASK_SET_VIEW_OFS);
    assign hit_clr = view_hit(i_addr, `IRQ_MASK_CLEAR_VIEW_OFS);
    assign hit_view = hit_set | hit_clr;
    assign set_we = i_wr & hit_set;
    assign clr_we = i_wr & hit_clr;

    // The master gate has no event of its own; bit 31 of the event word is ignored.
    wire en_master_irq_gate;
    wire wb_master_irq_gate;
    assign en_master_irq_gate = mask[`BIT_MASTER_IRQ_GATE];
    assign wb_master_irq_gate = i_wdata[`BIT_MASTER_IRQ_GATE];
    assign read_view[`BIT_MASTER_IRQ_GATE] = en_master_irq_gate;
    assign events_seen[`BIT_MASTER_IRQ_GATE] = 1'b0;
    assign write_bits[`BIT_MASTER_IRQ_GATE] = wb_master_irq_gate;

    wire en_ownership_change;
    wire ev_ownership_change;
    wire wb_ownership_change;
    assign en_ownership_change = mask[`BIT_OWNERSHIP_CHANGE];
    assign ev_ownership_change = i_irq_events[`BIT_OWNERSHIP_CHANGE];
    assign wb_ownership_change = i_wdata[`BIT_OWNERSHIP_CHANGE];
    assign read_view[`BIT_OWNERSHIP_CHANGE] = en_ownership_change;
    assign events_seen[`BIT_OWNERSHIP_CHANGE] = ev_ownership_change;
    assign write_bits[`BIT_OWNERSHIP_CHANGE] = wb_ownership_change;

    wire en_root_hub_change;
    wire ev_root_hub_change;
    wire wb_root_hub_change;
    assign en_root_hub_change = mask[`BIT_ROOT_HUB_CHANGE];
    assign ev_root_hub_change = i_irq_events[`BIT_ROOT_HUB_CHANGE];
    assign wb_root_hub_change = i_wdata[`BIT_ROOT_HUB_CHANGE];
    assign read_view[`BIT_ROOT_HUB_CHANGE] = en_root_hub_change;
    assign events_seen[`BIT_ROOT_HUB_CHANGE] = ev_root_hub_change;
    assign write_bits[`BIT_ROOT_HUB_CHANGE] = wb_root_hub_change;

    wire en_frame_count_wrap;
    wire ev_frame_count_wrap;
    wire wb_frame_count_wrap;
    assign en_frame_count_wrap = mask[`BIT_FRAME_COUNT_WRAP];
    assign ev_frame_count_wrap = i_irq_events[`BIT_FRAME_COUNT_WRAP];
    assign wb_frame_count_wrap = i_wdata[`BIT_FRAME_COUNT_WRAP];
    assign read_view[`BIT_FRAME_COUNT_WRAP] = en_frame_count_wrap;
    assign events_seen[`BIT_FRAME_COUNT_WRAP] = ev_frame_count_wrap;
    assign write_bits[`BIT_FRAME_COUNT_WRAP] = wb_frame_count_wrap;

    // A fatal error stays silent while its enable is clear; software must poll for it.
    wire en_fatal_system_error;
    wire ev_fatal_system_error;
    wire wb_fatal_system_error;
    assign en_fatal_system_error = mask[`BIT_FATAL_SYSTEM_ERROR];
    assign ev_fatal_system_error = i_irq_events[`BIT_FATAL_SYSTEM_ERROR];
    assign wb_fatal_system_error = i_wdata[`BIT_FATAL_SYSTEM_ERROR];
    assign read_view[`BIT_FATAL_SYSTEM_ERROR] = en_fatal_system_error;
    assign events_seen[`BIT_FATAL_SYSTEM_ERROR] = ev_fatal_system_error;
    assign write_bits[`BIT_FATAL_SYSTEM_ERROR] = wb_fatal_system_error;

    wire en_resume_seen;
    wire ev_resume_seen;
    wire wb_resume_seen;
    assign en_resume_seen = mask[`BIT_RESUME_SEEN];
    assign ev_resume_seen = i_irq_events[`BIT_RESUME_SEEN];
    assign wb_resume_seen = i_wdata[`BIT_RESUME_SEEN];
    assign read_view[`BIT_RESUME_SEEN] = en_resume_seen;
    assign events_seen[`BIT_RESUME_SEEN] = ev_resume_seen;
    assign write_bits[`BIT_RESUME_SEEN] = wb_resume_seen;

    // Frame starts come every frame, so this enable is usually left clear.
    wire en_frame_start;
    wire ev_frame_start;
    wire wb_frame_start;
    assign en_frame_start = mask[`BIT_FRAME_START];
    assign ev_frame_start = i_irq_events[`BIT_FRAME_START];
    assign wb_frame_start = i_wdata[`BIT_FRAME_START];
    assign read_view[`BIT_FRAME_START] = en_frame_start;
    assign events_seen[`BIT_FRAME_START] = ev_frame_start;
    assign write_bits[`BIT_FRAME_START] = wb_frame_start;

    wire en_done_list_written;
    wire ev_done_list_written;
    wire wb_done_list_written;
    assign en_done_list_written = mask[`BIT_DONE_LIST_WRITTEN];
    assign ev_done_list_written = i_irq_events[`BIT_DONE_LIST_WRITTEN];
    assign wb_done_list_written = i_wdata[`BIT_DONE_LIST_WRITTEN];
    assign read_view[`BIT_DONE_LIST_WRITTEN] = en_done_list_written;
    assign events_seen[`BIT_DONE_LIST_WRITTEN] = ev_done_list_written;
    assign write_bits[`BIT_DONE_LIST_WRITTEN] = wb_done_list_written;

    wire en_schedule_overrun;
    wire ev_schedule_overrun;
    wire wb_schedule_overrun;
    assign en_schedule_overrun = mask[`BIT_SCHEDULE_OVERRUN];
    assign ev_schedule_overrun = i_irq_events[`BIT_SCHEDULE_OVERRUN];
    assign wb_schedule_overrun = i_wdata[`BIT_SCHEDULE_OVERRUN];
    assign read_view[`BIT_SCHEDULE_OVERRUN] = en_schedule_overrun;
    assign events_seen[`BIT_SCHEDULE_OVERRUN] = ev_schedule_overrun;
    assign write_bits[`BIT_SCHEDULE_OVERRUN] = wb_schedule_overrun;

    // Reserved positions are dropped on the way in, so a careless write cannot arm them.
    genvar rv;
    generate
        for (rv = 7; rv < 30; rv = rv + 1) begin : g_resv
            assign read_view[rv] = 1'b0;
            assign events_seen[rv] = 1'b0;
            assign write_bits[rv] = 1'b0;
        end
    endgenerate

    // One store serves both views, so neither view can drift from the other.
    irq_mask_store u_store (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_soft_rst(i_soft_rst),
        .i_set_we(set_we),
        .i_clr_we(clr_we),
        .i_wdata(write_bits),
        .i_be(i_be),
        .o_mask(mask)
    );

    irq_gate u_gate (
        .i_mask(read_view),
        .i_events(events_seen),
        .o_req(req)
    );

    always @* begin
        nxt_rvalid = i_rd;
        nxt_rdata = 32'h00000000;
        // Unmapped reads return zero rather than stale data.
        if (i_rd && hit_view) begin
            nxt_rdata = read_view;
        end
        // Soft reset clears the gate in the same cycle, so no request leaks out.
        nxt_irq_req = req & ~i_soft_rst;
    end

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= nxt_rvalid;
        end
    end

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h00000000;
        end else begin
            o_rdata <= nxt_rdata;
        end
    end

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_req <= 1'b0;
        end else begin
            o_irq_req <= nxt_irq_req;
        end
    end
endmodule

// *** testbench/irq_chk_assertions.sv ***
`timescale 1ns/1ps
`include "irq_mask_map.vh"
module irq_chk (
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_soft_rst,
    input wire [7:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [3:0] i_be,
    input wire [31:0] i_wdata,
    input wire [31:0] i_irq_events,
    input wire [31:0] o_rdata,
    input wire o_rvalid,
    input wire o_irq_req
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence s_gate_clear;
        i_wr && (i_addr == `IRQ_MASK_CLEAR_VIEW_OFS) && i_be[3] && i_wdata[31];
    endsequence
    sequence s_soft_then_read;
        i_soft_rst ##1 !i_wr ##1 (i_rd && !i_wr && (i_addr == `IRQ_MASK_SET_VIEW_OFS));
    endsequence
    property p_rv; i_rd |=> o_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_idle; !i_rd |=> (!o_rvalid && (o_rdata == 32'h00000000)); endproperty
    a_idle: assert property (p_idle) else $error("read data without a read");
    property p_unmapped;
        (i_rd && (i_addr != `IRQ_MASK_SET_VIEW_OFS) && (i_addr != `IRQ_MASK_CLEAR_VIEW_OFS)) |=>
            (o_rdata == 32'h00000000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_sr; i_soft_rst |=> !o_irq_req; endproperty
    a_sr: assert property (p_sr) else $error("request after soft reset");
    property p_gate_clear; s_gate_clear |=> ##1 !o_irq_req; endproperty
    a_gate_clear: assert property (p_gate_clear) else $error("request with gate cleared");
    property p_no_event; (i_irq_events[30:0] == 31'h00000000) |=> !o_irq_req; endproperty
    a_no_event: assert property (p_no_event) else $error("request without event");
    property p_soft_read; s_soft_then_read |=> (o_rdata == 32'h00000000); endproperty
    a_soft_read: assert property (p_soft_read) else $error("mask not cleared by soft reset");
endmodule
bind usb_host_irq_mask_set_clear irq_chk u_chk (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_soft_rst(i_soft_rst),
    .i_addr(i_addr),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_be(i_be),
    .i_wdata(i_wdata),
    .i_irq_events(i_irq_events),
    .o_rdata(o_rdata),
    .o_rvalid(o_rvalid),
    .o_irq_req(o_irq_req)
);

// *** testbench/evt_src.sv ***
`timescale 1ns/1ps
module evt_src(input wire i_mclk, input wire [31:0] i_pat, output reg [31:0] o_ev);
    always @(posedge i_mclk) o_ev <= i_pat;
endmodule

// *** testbench/usb_host_irq_mask_set_clear_tb_top.sv ***
`timescale 1ns/1ps
`include "irq_mask_map.vh"
module usb_host_irq_mask_set_clear_tb_top;
reg i_mclk = 1'b0;
reg i_rst_n = 1'b0;
reg i_wr = 1'b0;
reg i_rd = 1'b0;
reg i_soft_rst = 1'b0;
reg [7:0] i_addr = 8'h00;
reg [3:0] i_be = 4'hf;
reg [31:0] i_wdata = 32'h00000000;
reg [31:0] pat = 32'h00000000;
reg [31:0] m = 32'h00000000;
reg [31:0] r = 32'h75d3ae4e;
reg [31:0] lanes = 32'h00000000;
wire [31:0] o_rdata, ev;
wire o_rvalid, o_irq_req;
integer mismatches = 0, checked = 0, i;
reg [31:0] q[$];
always #20 i_mclk = ~i_mclk;
evt_src u_src(.i_mclk(i_mclk), .i_pat(pat), .o_ev(ev));
usb_host_irq_mask_set_clear dut(.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_soft_rst(i_soft_rst),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_be(i_be), .i_wdata(i_wdata),
    .i_irq_events(ev), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_irq_req(o_irq_req));
function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task cmp(input [31:0] e, input [31:0] g); begin
    checked = checked + 1;
    if (e !== g) begin
        mismatches = mismatches + 1;
        $display("FAIL %0t exp %h got %h", $time, e, g);
    end
end endtask
task acc(input w, input [7:0] a, input [31:0] d, input [3:0] be); begin
    @(posedge i_mclk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    i_be <= be;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    if (!w) q.push_back((a == 8'h10 || a == 8'h14) ? m : 32'h00000000);
    if (w && a == 8'h10) m = m | (d & lanes & `IRQ_MASK_IMPL);
    if (w && a == 8'h14) m = m & ~(d & lanes & `IRQ_MASK_IMPL);
    @(posedge i_mclk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
end endtask
task chk_irq; begin
    #1;
    cmp({31'h00000000, m[31] & |(pat[30:0] & m[30:0])}, {31'h00000000, o_irq_req});
end endtask
task give_verdict; begin
    if (q.size() != 0) mismatches = mismatches + 1;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
end endtask
always @(negedge i_mclk) if (o_rvalid === 1'b1) cmp(q.size() ? q.pop_front() : 32'hdead0000, o_rdata);
initial begin
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1;
    acc(1'b0, 8'h14, 32'h00000000, 4'hf);
    pat <= 32'h00000001;
    acc(1'b1, 8'h10, 32'h80000001, 4'hf);
    acc(1'b0, 8'h14, 32'h00000000, 4'hf);
    chk_irq;
    acc(1'b1, 8'h14, 32'h80000000, 4'h8);
    acc(1'b0, 8'h10, 32'h00000000, 4'hf);
    chk_irq;
    $display("walk test done");
    for (i = 0; i < 60; i = i + 1) begin
        r = nx(r);
        pat <= nx(r);
        // Reserved bits are kept at zero, as software must write them.
        acc(1'b1, r[1] ? 8'h14 : (r[0] ? 8'h10 : 8'h18), r & `IRQ_MASK_IMPL, r[4] ? 4'hf : r[11:8]);
        acc(1'b0, r[2] ? 8'h10 : (r[3] ? 8'h14 : 8'h0c), 32'h00000000, 4'hf);
        chk_irq;
    end
    $display("random test done");
    @(posedge i_mclk) i_soft_rst <= 1'b1;
    @(posedge i_mclk) i_soft_rst <= 1'b0;
    m = 32'h00000000;
    acc(1'b0, 8'h10, 32'h00000000, 4'hf);
    chk_irq;
    repeat (3) @(posedge i_mclk);
    $display("reset test done");
    give_verdict;
end
endmodule
